//--- inc/lcdpt_pkg.sv
// Purpose: Shared constants for the LCD panel timing and power-save block.
// Assumes: 100 MHz mclk, Avalon-MM register slave with 32-bit data.
// Notes: Register offsets are byte addresses on the slave port.
// Functional notes
// - Shift clock period is 4, 8 or 16 mclk for strap 00, 01, 10.
// - Host access window opens at the line pulse falling edge, also an interrupt.
// - Window lasts (total-row - row - K) x divider x 2 mclk, K 3/2/1 by depth.
// - Indirect mode power save turns the panel power off within two frames.
// - Indirect display-off command 58h turns panel power off within one mclk.
// - Direct mode clearing display enable turns panel power off within two mclk.
// - Switching the display on with power save clear raises panel power within two mclk.
// - Power save is bit 0 of its register, display on is bit 0 of its own.
// - Panel nibble is stable around each falling edge of the shift clock.
// - Line pulse falls at least two shift periods before frame pulse falls.
// - Line pulse falls at least two shift periods after frame pulse rises.
// - Frame pulse stays high three shift periods after row-scan clock falls.
// - The block holds 32K bytes of embedded memory for display data.
package lcdpt_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 10;
  // Register byte offsets (index times four where the index is printed)
  localparam logic [7:0] IDX_POWER_SAVE = 8'h08;
  localparam logic [7:0] IDX_DISPLAY_EN = 8'h09;
  localparam logic [7:0] OFS_POWER_SAVE = 8'h20;
  localparam logic [7:0] OFS_DISPLAY_EN = 8'h24;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ROW_BYTES = 8'h04;
  localparam logic [7:0] OFS_TOTAL_ROW = 8'h08;
  localparam logic [7:0] OFS_FRAME_LINES = 8'h0C;
  localparam logic [7:0] OFS_START_ADDR = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h28;
  localparam logic [7:0] OFS_MEM_DATA = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h34;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h38;
  // Field positions
  localparam int CFG_INDIRECT_BIT = 0;
  localparam int CFG_BPP_LSB = 1;
  localparam int IRQ_WINDOW_BIT = 0;
  localparam int IRQ_FRAME_BIT = 1;
  // Command codes
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'h58;
  // Depth select codes and window margins
  localparam logic [1:0] BPP_1 = 2'h0;
  localparam logic [1:0] BPP_2 = 2'h1;
  localparam logic [9:0] WIN_K_1BPP = 10'h003;
  localparam logic [9:0] WIN_K_2BPP = 10'h002;
  localparam logic [9:0] WIN_K_4BPP = 10'h001;
  // Divider as log2 of the shift period in mclk
  localparam logic [2:0] DIV_LOG_4 = 3'h2;
  localparam logic [2:0] DIV_LOG_8 = 3'h3;
  localparam logic [2:0] DIV_LOG_16 = 3'h4;
  localparam logic [2:0] DIV_LOG_RST = 3'h4;
  localparam logic [4:0] TICK_CNT_RST = 5'h1F;
  // Frame pulse placement around the line pulse, in shift periods
  localparam logic [8:0] LP_AFTER_DATA = 9'h002;
  localparam logic [8:0] FP_LEAD = 9'h002;
  localparam logic [8:0] FP_TRAIL = 9'h003;
  // Memory
  localparam int MEM_BYTES = 32768;
  localparam int MEM_AW = 15;
  // Reset values
  localparam logic RST_WAITREQ = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Power control states, Gray along OFF, ON, SAVE_WAIT
  typedef enum logic [1:0] {
    LCDPT_OFF = 2'b00,
    LCDPT_ON = 2'b01,
    LCDPT_SAVE_WAIT = 2'b11
  } lcdpt_pwr_e;
endpackage : lcdpt_pkg

//--- core/lcdpt_ticker.sv
// Purpose: Divides mclk into the pixel shift clock and a period tick.
// Assumes: div_log is 2, 3 or 4 and stays still while running.
// Notes: tick is high in the last mclk of each shift period.
`timescale 1ns/1ps
`default_nettype none
module lcdpt_ticker
  import lcdpt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] div_log,
  output logic tick,
  output logic shift_clk
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
    logic sclk;
  } lcdpt_tick_s;

  lcdpt_tick_s s;
  lcdpt_tick_s next_s;
  logic [4:0] last;
  logic [4:0] half;

  // Counter wraps at the divider, clock high in the first half
  always_comb
  begin
    next_s = s;
    last = 5'((6'h01 << div_log) - 6'h01);
    half = 5'(6'h01 << (div_log - 3'h1));
    next_s.cnt = (s.cnt == last) ? 5'h00 : 5'(s.cnt + 5'h01);
    next_s.tick = (next_s.cnt == last);
    next_s.sclk = (next_s.cnt < half);
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{cnt: TICK_CNT_RST, tick: 1'b0, sclk: 1'b0}; // Wraps to zero, first period whole
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
  assign shift_clk = s.sclk;
endmodule : lcdpt_ticker
`default_nettype wire

//--- core/lcdpt_timing.sv
// Purpose: LCD panel timing, display memory, power-off control and registers.
// Assumes: Avalon-MM slave, byte addresses, one wait state per access.
// Notes: Strap is caught once right after reset release.
`timescale 1ns/1ps
`default_nettype none
module lcdpt_timing
  import lcdpt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] divider_strap,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pixel_shift_clock,
  output logic line_pulse,
  output logic frame_pulse,
  output logic row_scan_clock,
  output logic [3:0] panel_pixel_bus,
  output logic panel_power_off,
  output logic access_window,
  output logic irq
);
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic strap_done;
    logic [2:0] div_log;
    logic cfg_indirect;
    logic [1:0] cfg_bpp;
    logic [7:0] row_bytes;
    logic [7:0] total_row;
    logic [7:0] frame_lines;
    logic [14:0] start_addr;
    logic psave;
    logic disp_en;
    logic [14:0] mem_addr;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic irq;
    lcdpt_pwr_e pstate;
    logic [8:0] pcnt;
    logic [7:0] lcnt;
    logic lp;
    logic fp;
    logic rsc;
    logic [3:0] pix;
    logic ppo;
    logic [15:0] win_cnt;
    logic win;
  } lcdpt_state_s;

  lcdpt_state_s s;
  lcdpt_state_s next_s;
  logic rst_meta;
  logic rst_sync;
  logic tick;
  logic shift_clk;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic accept;
  logic wr_ok;
  logic [8:0] np;
  logic [7:0] nl;
  logic [8:0] lp_pos;
  logic [14:0] fetch_addr;
  logic [7:0] fetch_byte;
  logic [7:0] host_byte;
  logic [9:0] win_k;
  logic [9:0] win_bytes;
  logic line_fall;
  logic frame_fall;
  logic [1:0] events;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Shift clock divider
  lcdpt_ticker u_ticker (
    .mclk(mclk),
    .rst_n(rst_sync),
    .div_log(s.div_log),
    .tick(tick),
    .shift_clk(shift_clk)
  );

  // Display memory, host writes through the data port
  always_ff @(posedge mclk)
  begin
    if (wr_ok && avs_address == OFS_MEM_DATA)
    begin
      mem[s.mem_addr] <= avs_writedata[7:0];
    end
  end

  // Bus handshake and memory read ports
  always_comb
  begin
    accept = (avs_read || avs_write) && !s.waitreq;
    wr_ok = accept && avs_write && avs_byteenable[0];
    host_byte = mem[s.mem_addr];
    fetch_byte = mem[fetch_addr];
  end

  // Position of the next shift period and the pixel fetch address
  always_comb
  begin
    np = (s.pcnt == {s.total_row, 1'b1}) ? 9'h000 : 9'(s.pcnt + 9'h001);
    // Line of the next period, so the first nibble of a line comes from that line
    nl = (np != 9'h000) ? s.lcnt : ((s.lcnt == s.frame_lines) ? 8'h00 : 8'(s.lcnt + 8'h01));
    lp_pos = 9'({s.row_bytes, 1'b0} + LP_AFTER_DATA);
    fetch_addr = 15'(s.start_addr + 15'(nl) * 15'({1'b0, s.row_bytes} + 9'h001)
                 + 15'(np[8:1]));
    case (s.cfg_bpp)
      BPP_1: win_k = WIN_K_1BPP;
      BPP_2: win_k = WIN_K_2BPP;
      default: win_k = WIN_K_4BPP;
    endcase
    win_bytes = 10'({2'b00, s.total_row} - {2'b00, s.row_bytes} - win_k);
  end

  // Next state of the whole block
  always_comb
  begin
    next_s = s;
    line_fall = 1'b0;
    frame_fall = 1'b0;
    // Strap capture once after release, 11 falls back to divide by 16
    if (!s.strap_done)
    begin
      next_s.strap_done = 1'b1;
      case (divider_strap)
        2'b00: next_s.div_log = DIV_LOG_4;
        2'b01: next_s.div_log = DIV_LOG_8;
        2'b10: next_s.div_log = DIV_LOG_16;
        default: next_s.div_log = DIV_LOG_16;
      endcase
    end
    // Wait state: low for one cycle after a request is seen
    next_s.waitreq = !((avs_read || avs_write) && s.waitreq);
    // Register reads
    if ((avs_read || avs_write) && s.waitreq)
    begin
      next_s.rdata = 32'h0000_0000;
      case (avs_address)
        OFS_CONFIG: next_s.rdata = {29'h0, s.cfg_bpp, s.cfg_indirect};
        OFS_ROW_BYTES: next_s.rdata = {24'h0, s.row_bytes};
        OFS_TOTAL_ROW: next_s.rdata = {24'h0, s.total_row};
        OFS_FRAME_LINES: next_s.rdata = {24'h0, s.frame_lines};
        OFS_START_ADDR: next_s.rdata = {17'h0, s.start_addr};
        OFS_STATUS: next_s.rdata = {26'h0, s.div_log, s.pstate == LCDPT_SAVE_WAIT, s.win, s.ppo};
        OFS_POWER_SAVE: next_s.rdata = {31'h0, s.psave};
        OFS_DISPLAY_EN: next_s.rdata = {31'h0, s.disp_en};
        OFS_MEM_ADDR: next_s.rdata = {17'h0, s.mem_addr};
        OFS_MEM_DATA: next_s.rdata = {24'h0, host_byte};
        OFS_IRQ_STATUS: next_s.rdata = {30'h0, s.irq_stat};
        OFS_IRQ_ENABLE: next_s.rdata = {30'h0, s.irq_en};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes take effect on the accepting edge
    if (wr_ok)
    begin
      case (avs_address)
        OFS_CONFIG:
        begin
          next_s.cfg_indirect = avs_writedata[CFG_INDIRECT_BIT];
          next_s.cfg_bpp = avs_writedata[CFG_BPP_LSB +: 2];
        end
        OFS_ROW_BYTES: next_s.row_bytes = avs_writedata[7:0];
        OFS_TOTAL_ROW: next_s.total_row = avs_writedata[7:0];
        OFS_FRAME_LINES: next_s.frame_lines = avs_writedata[7:0];
        OFS_START_ADDR: next_s.start_addr = avs_writedata[14:0];
        OFS_POWER_SAVE: next_s.psave = avs_writedata[0];
        OFS_DISPLAY_EN: next_s.disp_en = avs_writedata[0];
        OFS_MEM_ADDR: next_s.mem_addr = avs_writedata[14:0];
        OFS_IRQ_ENABLE: next_s.irq_en = avs_writedata[1:0];
        OFS_COMMAND:
        begin
          if (s.cfg_indirect && avs_writedata[7:0] == CMD_DISPLAY_OFF)
          begin
            next_s.disp_en = 1'b0;
          end
        end
        default: next_s.disp_en = next_s.disp_en;
      endcase
    end
    // Data port walks through memory on each access
    if (accept && avs_address == OFS_MEM_DATA)
    begin
      next_s.mem_addr = 15'(s.mem_addr + 15'h0001);
    end
    // Panel scan, one step per shift period
    if (tick)
    begin
      next_s.pcnt = np;
      next_s.lcnt = nl;
      // High nibble first, changed at the rising edge, held past the fall
      if (np[8:1] <= s.row_bytes && s.ppo)
      begin
        next_s.pix = np[0] ? fetch_byte[3:0] : fetch_byte[7:4];
      end
      else
      begin
        next_s.pix = 4'h0;
      end
      next_s.lp = (np == lp_pos);
      next_s.rsc = (np == lp_pos);
      // Frame pulse spans the last line's pulse with margin both sides
      next_s.fp = 1'b0;
      if (next_s.lcnt == s.frame_lines && np >= 9'(lp_pos - FP_LEAD)
          && np <= 9'(lp_pos + FP_TRAIL))
      begin
        next_s.fp = 1'b1;
      end
      line_fall = s.lp && !next_s.lp;
      frame_fall = s.fp && !next_s.fp;
    end
    // Access window opens at the line pulse fall
    if (line_fall)
    begin
      next_s.win_cnt = win_bytes[9] ? 16'h0000
                       : 16'({8'h00, win_bytes[7:0]} << (s.div_log + 3'h1));
    end
    else if (s.win_cnt != 16'h0000)
    begin
      next_s.win_cnt = 16'(s.win_cnt - 16'h0001);
    end
    next_s.win = (next_s.win_cnt != 16'h0000);
    // Sticky events, a set in the clearing cycle wins
    events = 2'b00;
    events[IRQ_WINDOW_BIT] = line_fall;
    events[IRQ_FRAME_BIT] = frame_fall;
    next_s.irq_stat = s.irq_stat;
    if (wr_ok && avs_address == OFS_IRQ_CLEAR)
    begin
      next_s.irq_stat = s.irq_stat & ~avs_writedata[1:0];
    end
    next_s.irq_stat = next_s.irq_stat | events;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    // Panel power control
    case (s.pstate)
      LCDPT_OFF:
      begin
        if (next_s.disp_en && !next_s.psave)
        begin
          next_s.pstate = LCDPT_ON;
        end
      end
      LCDPT_ON:
      begin
        if (!next_s.disp_en)
        begin
          next_s.pstate = LCDPT_OFF;
        end
        else if (next_s.psave)
        begin
          next_s.pstate = s.cfg_indirect ? LCDPT_SAVE_WAIT : LCDPT_OFF;
        end
      end
      LCDPT_SAVE_WAIT:
      begin
        if (!next_s.disp_en || frame_fall)
        begin
          next_s.pstate = LCDPT_OFF;
        end
        else if (!next_s.psave)
        begin
          next_s.pstate = LCDPT_ON;
        end
      end
      default: next_s.pstate = LCDPT_OFF;
    endcase
    next_s.ppo = (next_s.pstate != LCDPT_OFF);
  end

  // State register
  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      s <= '0;
      s.waitreq <= RST_WAITREQ;
      s.div_log <= DIV_LOG_RST;
      s.frame_lines <= RST_BYTE;
      s.pstate <= LCDPT_OFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign pixel_shift_clock = shift_clk;
  assign line_pulse = s.lp;
  assign frame_pulse = s.fp;
  assign row_scan_clock = s.rsc;
  assign panel_pixel_bus = s.pix;
  assign panel_power_off = s.ppo;
  assign access_window = s.win;
  assign irq = s.irq;
endmodule : lcdpt_timing
`default_nettype wire

//--- sim/lcdpt_asserts.sv
// Purpose: Port checker for the LCD panel timing block.
// Assumes: Strap held still while out of reset.
// Notes: Pulse placement is judged once a frame follows the row setup.
`timescale 1ns/1ps
`default_nettype none
module lcdpt_asserts
  import lcdpt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] divider_strap,
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic pixel_shift_clock,
  input wire logic line_pulse,
  input wire logic frame_pulse,
  input wire logic row_scan_clock,
  input wire logic [3:0] panel_pixel_bus,
  input wire logic panel_power_off,
  input wire logic access_window
);
  logic [9:0] per, c_sh, c_lf, c_fr, c_sf;
  logic p_sh, p_lp, p_fp, p_sc, seen, ind, ps, arm, pl, wr, rs, lf, ff;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Accepted writes, edge strobes and expected shift period
  assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rs = pixel_shift_clock && !p_sh;
  assign lf = p_lp && !line_pulse;
  assign ff = p_fp && !frame_pulse;
  assign per = (divider_strap == 2'h0) ? 10'h004 : ((divider_strap == 2'h1) ? 10'h008 : 10'h010);
  // Edge history, cycle counters and tracked mode bits
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {p_sh, p_lp, p_fp, p_sc, seen, ind, ps, arm, pl} <= '0;
      {c_sh, c_lf, c_fr, c_sf} <= '0;
    end
    else
    begin
      {p_sh, p_lp, p_fp, p_sc} <= {pixel_shift_clock, line_pulse, frame_pulse, row_scan_clock};
      seen <= seen | rs;
      c_sh <= rs ? 10'h001 : c_sh + 10'h001;
      c_lf <= lf ? 10'h001 : c_lf + 10'h001;
      c_fr <= (frame_pulse && !p_fp) ? 10'h001 : c_fr + 10'h001;
      c_sf <= (p_sc && !row_scan_clock) ? 10'h001 : c_sf + 10'h001;
      if (wr && avs_address == OFS_CONFIG)
        ind <= avs_writedata[CFG_INDIRECT_BIT];
      if (wr && avs_address == OFS_POWER_SAVE)
        ps <= avs_writedata[0];
      if (wr && avs_address == OFS_TOTAL_ROW)
        arm <= 1'b1;
      pl <= pl | (arm & ff);
    end
  end
  a_shift_period: assert property (rs && seen |-> c_sh == per)
    else $error("shift clock period wrong for strap");
  a_data_stable: assert property (
    $fell(pixel_shift_clock) && $stable(panel_power_off) |-> $stable(panel_pixel_bus))
    else $error("panel nibble moved at shift fall");
  a_window_open: assert property (
    $rose(access_window) |-> $past(line_pulse) || $past(line_pulse, 2))
    else $error("access window opened away from line fall");
  a_line_before_frame: assert property (pl && ff |-> c_lf >= 2 * per)
    else $error("frame fell too soon after line fall");
  a_line_after_frame: assert property (pl && lf && frame_pulse |-> c_fr >= 2 * per - 1)
    else $error("line fell too soon after frame rise");
  a_frame_hold: assert property (pl && ff |-> c_sf >= 3 * per - 1)
    else $error("frame fell too soon after row scan fall");
  a_cmd_off: assert property (wr && ind && avs_address == OFS_COMMAND
    && avs_writedata[7:0] == CMD_DISPLAY_OFF |=> !panel_power_off)
    else $error("panel power stayed on after off command");
  a_disp_off: assert property (wr && avs_address == OFS_DISPLAY_EN && !avs_writedata[0]
    |-> ##[1:2] !panel_power_off)
    else $error("panel power stayed on after display disable");
  a_disp_on: assert property (wr && !ps && avs_address == OFS_DISPLAY_EN && avs_writedata[0]
    |-> ##[1:2] panel_power_off)
    else $error("panel power late after display enable");
endmodule : lcdpt_asserts
bind lcdpt_timing lcdpt_asserts u_chk (.mclk, .reset_n, .divider_strap, .avs_address,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .pixel_shift_clock,
  .line_pulse, .frame_pulse, .row_scan_clock, .panel_pixel_bus, .panel_power_off,
  .access_window);
`default_nettype wire

//--- sim/lcdpt_panel.sv
// Purpose: Panel model that latches the nibbles of each line.
// Assumes: Two bytes a line, so four nibbles precede each line pulse.
// Notes: Keeps the first line and the last line of a frame.
`timescale 1ns/1ps
`default_nettype none
module lcdpt_panel
(
  input wire logic pixel_shift_clock,
  input wire logic line_pulse,
  input wire logic frame_pulse,
  input wire logic [3:0] panel_pixel_bus,
  output logic [15:0] first_line,
  output logic [15:0] last_line
);
  logic [15:0] sr = 16'h0000;
  logic nxt = 1'b0;
  initial
  begin
    first_line = 16'h0000;
    last_line = 16'h0000;
  end
  // Sample on the falling shift edge; a line is latched during its pulse
  always @(negedge pixel_shift_clock)
  begin
    if (line_pulse && frame_pulse)
    begin
      last_line <= sr;
      nxt <= 1'b1;
    end
    else if (line_pulse && nxt)
    begin
      first_line <= sr;
      nxt <= 1'b0;
    end
    sr <= {sr[11:0], panel_pixel_bus};
  end
endmodule : lcdpt_panel
`default_nettype wire

//--- sim/tb.sv
// Purpose: Self-checking bench for the LCD panel timing block.
// Assumes: 100 MHz mclk; traffic runs with strap 01.
// Notes: Read results are queued and checked by a watcher process.
`timescale 1ns/1ps
`default_nettype none
module tb
  import lcdpt_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] divider_strap = 2'h3;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, seed = 32'h00003F23;
  logic avs_waitrequest, pixel_shift_clock, line_pulse, frame_pulse, row_scan_clock;
  logic [3:0] panel_pixel_bus;
  logic panel_power_off, access_window, irq;
  logic [15:0] first_line, last_line;
  logic [31:0] q[$];
  logic [7:0] b[4];
  logic [1:0] stp[4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  logic [31:0] ptab[4] = '{32'h10, 32'h10, 32'h4, 32'h8};
  int err_total = 0;
  int checked = 0;
  int nfr = 0;
  int h, l, n0;
  logic prev_w = 1'b0;
  lcdpt_timing u_dut (.mclk, .reset_n, .divider_strap, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pixel_shift_clock,
    .line_pulse, .frame_pulse, .row_scan_clock, .panel_pixel_bus, .panel_power_off,
    .access_window, .irq);
  lcdpt_panel u_pan (.pixel_shift_clock, .line_pulse, .frame_pulse, .panel_pixel_bus,
    .first_line, .last_line);
  // Clock and frame counter
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  always @(negedge frame_pulse) nfr <= nfr + 1;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic wrap_up();
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s)
    begin
      err_total++;
      $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  endtask : chk
  task automatic tmo(input string nm);
    err_total++;
    $display("BAD %s exp done got timeout", nm);
    wrap_up();
  endtask : tmo
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    // Idle spacing before each cycle, longer after a write
    repeat (prev_w ? 8 : 3) @(posedge mclk);
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 50)
      tmo("waitrequest");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    prev_w = w;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_lvl(ref logic s, input logic v);
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge mclk);
      if (s === v)
        return;
    end
    tmo("level");
  endtask : wait_lvl
  task automatic run(ref logic s, input logic v, output int n);
    n = 0;
    while (s === v && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 4000)
      tmo("run");
  endtask : run
  task automatic wset(input logic [7:0] a, input logic [31:0] d, ref logic s, input logic e);
    wr(a, d);
    repeat (2) @(posedge mclk);
    chk("level_after_write", {31'h0, e}, {31'h0, s});
  endtask : wset
  task automatic rst(input logic [1:0] s);
    reset_n <= 1'b0;
    divider_strap <= s;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : rst
  // Read watcher takes the oldest note at each read answer
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0)
      chk("readdata", q.pop_front(), avs_readdata);
  // Main sequence
  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      rst(stp[k]);
      wait_lvl(pixel_shift_clock, 1'b0);
      wait_lvl(pixel_shift_clock, 1'b1);
      run(pixel_shift_clock, 1'b1, h);
      run(pixel_shift_clock, 1'b0, l);
      chk("shift_period", ptab[k], 32'(h + l));
    end
    wr(OFS_ROW_BYTES, 32'h1);
    wr(OFS_TOTAL_ROW, 32'h7);
    wr(OFS_FRAME_LINES, 32'h1);
    wr(OFS_START_ADDR, 32'h0);
    foreach (b[i]) b[i] = 8'(xs());
    wait_lvl(access_window, 1'b1);
    wr(OFS_MEM_ADDR, 32'h0);
    foreach (b[i]) wr(OFS_MEM_DATA, {24'h0, b[i]});
    wr(OFS_MEM_ADDR, 32'h0);
    foreach (b[i]) rd(OFS_MEM_DATA, {24'h0, b[i]});
    wr(OFS_MEM_ADDR, 32'h7FFF);
    wr(OFS_MEM_DATA, 32'hA5);
    wr(OFS_MEM_ADDR, 32'h7FFF);
    rd(OFS_MEM_DATA, 32'hA5);
    avs_byteenable <= 4'h0;
    wset(OFS_DISPLAY_EN, 32'h1, panel_power_off, 1'b0);
    avs_byteenable <= 4'hF;
    wset(OFS_DISPLAY_EN, 32'h1, panel_power_off, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      wait_lvl(frame_pulse, 1'b1);
      wait_lvl(frame_pulse, 1'b0);
    end
    chk("first_line", {16'h0, b[0], b[1]}, {16'h0, first_line});
    chk("last_line", {16'h0, b[2], b[3]}, {16'h0, last_line});
    for (int d = 0; d < 3; d++)
    begin
      wr(OFS_CONFIG, 32'(d) << CFG_BPP_LSB);
      wait_lvl(access_window, 1'b0);
      wait_lvl(access_window, 1'b1);
      run(access_window, 1'b1, h);
      chk("window", 32'((8 - 2 - (3 - d)) * 8 * 2), 32'(h));
    end
    wset(OFS_COMMAND, {24'h0, CMD_DISPLAY_OFF}, panel_power_off, 1'b1);
    wset(OFS_DISPLAY_EN, 32'h0, panel_power_off, 1'b0);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h3);
    wait_lvl(irq, 1'b1);
    chk("window_irq", 32'h1, {31'h0, access_window});
    wset(OFS_IRQ_ENABLE, 32'h0, irq, 1'b0);
    wset(OFS_IRQ_ENABLE, 32'h1, irq, 1'b1);
    wset(OFS_IRQ_CLEAR, 32'h1, irq, 1'b0);
    wset(OFS_DISPLAY_EN, 32'h1, panel_power_off, 1'b1);
    wr(OFS_CONFIG, 32'h1);
    wset(OFS_COMMAND, {24'h0, CMD_DISPLAY_OFF}, panel_power_off, 1'b0);
    rd(OFS_DISPLAY_EN, 32'h0);
    wset(OFS_DISPLAY_EN, 32'h1, panel_power_off, 1'b1);
    n0 = nfr;
    wr(OFS_POWER_SAVE, 32'h1);
    wait_lvl(panel_power_off, 1'b0);
    chk("save_frames", 32'h1, 32'(nfr - n0 <= 2));
    rd(OFS_POWER_SAVE, 32'h1);
    wset(OFS_POWER_SAVE, 32'h0, panel_power_off, 1'b1);
    rd(8'h3C, 32'h0);
    repeat (2) @(posedge mclk);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
